//--- design/dpm_pkg.sv
// constants and types shared by the dual port mailbox
package dpm_pkg;
  localparam int DW    = 32;
  localparam int AW    = 8;
  localparam int DEPTH = 16;
  localparam int PW    = $clog2(DEPTH);
  localparam int CW    = PW + 1;
  localparam int NINT  = 3;

  localparam logic [AW-1:0] OFF_WDATA   = 8'h00;
  localparam logic [AW-1:0] OFF_RDATA   = 8'h08;
  localparam logic [AW-1:0] OFF_STATUS  = 8'h10;
  localparam logic [AW-1:0] OFF_TX_THR  = 8'h18;
  localparam logic [AW-1:0] OFF_RX_THR  = 8'h1C;
  localparam logic [AW-1:0] OFF_INT_STS = 8'h20;
  localparam logic [AW-1:0] OFF_INT_MSK = 8'h24;

  // status and interrupt bit positions
  localparam int ST_RX_EMPTY  = 0;
  localparam int ST_TX_FULL   = 1;
  localparam int ST_RX_ABOVE  = 2;
  localparam int ST_TX_BELOW  = 3;
  localparam int INT_RX_THR   = 0;
  localparam int INT_TX_THR   = 1;
  localparam int INT_ERR      = 2;

  localparam logic [CW-1:0]   TX_THR_RST  = 5'h00;
  localparam logic [CW-1:0]   RX_THR_RST  = 5'h00;
  localparam logic [NINT-1:0] INT_MSK_RST = 3'h0;

  // access latency in cycles, setup cycle included
  localparam logic [3:0] LAT_LITE     = 4'h3;
  localparam logic [3:0] LAT_PLB      = 4'h5;
  localparam logic [3:0] LAT_BRAM_ADD = 4'h1;
  localparam logic [3:0] LAT_OFFSET   = 4'h3;

  typedef enum {IF_LITE, IF_PLB, IF_STREAM} dpm_ifsel_type;
  typedef enum {STORE_DIST, STORE_BRAM} dpm_store_type;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
    logic [3:0]    pstrb;
  } dpm_apb_req_type;

  typedef struct packed {
    logic [DW-1:0] prdata;
    logic          pready;
    logic          pslverr;
  } dpm_apb_rsp_type;

  typedef struct packed {
    logic          tvalid;
    logic [DW-1:0] tdata;
  } dpm_strm_type;
endpackage

//--- design/dpm_mailbox.sv
// two port processor mailbox: one fifo per direction, apb registers, stream ports
`timescale 1ns/1ps
// Notes on behaviour
// - each port independently memory-mapped or streaming
// - words cross to opposite port in order
// - fifo depth is a build-time constant
// - registers only on memory-mapped ports
// - status shows fifo state and thresholds
// - threshold crossings raise maskable interrupts
// - streaming ports show full and empty
// - port clock option is a parameter only: both ports run on pclk
// - distributed ram: lite 3, plb 5
// - block ram adds one write cycle
// - independent clocks keep access latency
// - independent block ram: write one longer
// - plb-style port answers as bus slave
// - write byte strobes are ignored
// - one shared reset acts on both ports
module dpm_mailbox import dpm_pkg::*; #(
  parameter dpm_ifsel_type port_a_interface_select = IF_LITE,
  parameter dpm_ifsel_type port_b_interface_select = IF_LITE,
  parameter dpm_store_type fifo_storage_style      = STORE_DIST,
  parameter bit            independent_port_clocks = 1'b0
) (
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // register bus per port
  input  wire dpm_apb_req_type apb_req  [2],
  output dpm_apb_rsp_type      apb_rsp  [2],
  // stream into each port
  input  wire dpm_strm_type    s_strm   [2],
  output logic                 s_tready [2],
  // stream out of each port
  output dpm_strm_type         m_strm   [2],
  input  wire logic            m_tready [2],
  // flags and interrupts
  output logic                 tx_full  [2],
  output logic                 rx_empty [2],
  output logic                 irq      [2]
);

  logic [DW-1:0] mem_r   [2][DEPTH];
  logic [PW-1:0] wp_r    [2];
  logic [PW-1:0] rp_r    [2];
  logic [CW-1:0] cnt_r   [2];
  logic [CW-1:0] cnt_nxt [2];
  logic          push    [2];
  logic          pop     [2];

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      localparam int            Q   = 1 - p;
      localparam dpm_ifsel_type SEL = (p == 0) ? port_a_interface_select : port_b_interface_select;
      localparam bit            MM  = (SEL != IF_STREAM);

      logic [3:0]      wcnt_r;
      logic [3:0]      lat;
      logic            acc;
      logic            fire;
      logic            wr_data;
      logic            rd_data;
      logic            known;
      logic            rd_req;
      logic [DW-1:0]   rdval;
      logic [CW-1:0]   tx_thr_r;
      logic [CW-1:0]   rx_thr_r;
      logic [NINT-1:0] int_msk_r;
      logic [NINT-1:0] int_sts_r;
      logic [NINT-1:0] int_sts_nxt;
      logic [NINT-1:0] ev;
      logic            rx_above;
      logic            tx_below;
      logic            rx_above_r;
      logic            tx_below_r;
      logic [3:0]      status;
      logic            wr_acc;
      logic [NINT-1:0] int_msk_nxt;

      // write on block ram storage costs one more cycle; clock option leaves latency alone
      always_comb begin
        lat = (SEL == IF_PLB) ? LAT_PLB : LAT_LITE;
        if (apb_req[p].pwrite && fifo_storage_style == STORE_BRAM) begin
          lat = lat + LAT_BRAM_ADD;
        end
      end

      assign acc  = apb_req[p].psel && apb_req[p].penable;
      // the answer is decided one edge before pready shows, so prdata is registered with it
      assign fire = acc && !apb_rsp[p].pready && (wcnt_r == lat - LAT_OFFSET);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wcnt_r <= 4'h0;
        end else if (!acc || apb_rsp[p].pready) begin
          wcnt_r <= 4'h0;
        end else begin
          wcnt_r <= wcnt_r + 4'h1;
        end
      end

      // pstrb is never looked at: every write is a full word
      assign wr_data = fire && MM && apb_req[p].pwrite && apb_req[p].paddr == OFF_WDATA;
      assign rd_data = fire && MM && !apb_req[p].pwrite && apb_req[p].paddr == OFF_RDATA;
      assign wr_acc  = fire && MM && apb_req[p].pwrite;

      always_comb begin
        case (apb_req[p].paddr)
          OFF_WDATA, OFF_RDATA, OFF_STATUS, OFF_TX_THR,
          OFF_RX_THR, OFF_INT_STS, OFF_INT_MSK: known = 1'b1;
          default: known = 1'b0;
        endcase
      end

      always_comb begin
        if (MM) begin
          push[p] = wr_data && cnt_r[p] != CW'(DEPTH);
          rd_req  = rd_data && cnt_r[Q] != '0;
        end else begin
          push[p] = s_strm[p].tvalid && s_tready[p];
          rd_req  = (!m_strm[p].tvalid || m_tready[p]) && cnt_r[Q] != '0;
        end
      end
      assign pop[Q] = rd_req;

      assign rx_above = cnt_r[Q] > rx_thr_r;
      assign tx_below = cnt_r[p] <= tx_thr_r;
      assign status   = {tx_below, rx_above, cnt_r[p] == CW'(DEPTH), cnt_r[Q] == '0};

      always_comb begin
        rdval = '0;
        case (apb_req[p].paddr)
          OFF_RDATA:   rdval = (cnt_r[Q] != '0) ? mem_r[Q][rp_r[Q]] : '0;
          OFF_STATUS:  rdval = DW'(status);
          OFF_TX_THR:  rdval = DW'(tx_thr_r);
          OFF_RX_THR:  rdval = DW'(rx_thr_r);
          OFF_INT_STS: rdval = DW'(int_sts_r);
          OFF_INT_MSK: rdval = DW'(int_msk_r);
          default:     rdval = '0;
        endcase
      end

      // a streaming port answers every register access with an error
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          apb_rsp[p] <= '0;
        end else begin
          apb_rsp[p].pready  <= fire;
          apb_rsp[p].pslverr <= fire && (!MM || !known);
          apb_rsp[p].prdata  <= (fire && MM && !apb_req[p].pwrite) ? rdval : '0;
        end
      end

      // thresholds and mask are written only over a memory-mapped port
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_thr_r <= TX_THR_RST;
        end else if (wr_acc && apb_req[p].paddr == OFF_TX_THR) begin
          tx_thr_r <= apb_req[p].pwdata[CW-1:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_thr_r <= RX_THR_RST;
        end else if (wr_acc && apb_req[p].paddr == OFF_RX_THR) begin
          rx_thr_r <= apb_req[p].pwdata[CW-1:0];
        end
      end

      always_comb begin
        int_msk_nxt = int_msk_r;
        if (wr_acc && apb_req[p].paddr == OFF_INT_MSK) begin
          int_msk_nxt = apb_req[p].pwdata[NINT-1:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          int_msk_r <= INT_MSK_RST;
        end else begin
          int_msk_r <= int_msk_nxt;
        end
      end

      // threshold events fire on crossing into the condition, not while it holds
      always_comb begin
        ev             = '0;
        ev[INT_RX_THR] = rx_above && !rx_above_r;
        ev[INT_TX_THR] = tx_below && !tx_below_r;
        ev[INT_ERR]    = (wr_data && cnt_r[p] == CW'(DEPTH)) || (rd_data && cnt_r[Q] == '0);
        int_sts_nxt    = int_sts_r;
        if (fire && MM && apb_req[p].pwrite && apb_req[p].paddr == OFF_INT_STS) begin
          int_sts_nxt = int_sts_r & ~apb_req[p].pwdata[NINT-1:0];
        end
        int_sts_nxt = int_sts_nxt | ev; // set wins over clear
      end

      // condition trackers start at their reset-state values (tx_below_r set, rx_above_r clear) so a quiet reset state raises nothing
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_above_r <= 1'b0;
          tx_below_r <= 1'b1;
        end else begin
          rx_above_r <= rx_above;
          tx_below_r <= tx_below;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          int_sts_r <= '0;
        end else begin
          int_sts_r <= int_sts_nxt;
        end
      end

      // next-state mask, so a mask write reaches irq without an extra cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq[p] <= 1'b0;
        end else begin
          irq[p] <= |(int_sts_nxt & int_msk_nxt);
        end
      end

      // registered output stage; on memory-mapped ports it stays idle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          m_strm[p] <= '0;
        end else if (!MM && rd_req) begin
          m_strm[p].tvalid <= 1'b1;
          m_strm[p].tdata  <= mem_r[Q][rp_r[Q]];
        end else if (m_tready[p]) begin
          m_strm[p].tvalid <= 1'b0;
        end
      end

      // flags follow the next count so a stream master never sees stale full
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s_tready[p] <= 1'b0;
        end else begin
          s_tready[p] <= !MM && cnt_nxt[p] != CW'(DEPTH);
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_full[p] <= 1'b0;
        end else begin
          tx_full[p] <= cnt_nxt[p] == CW'(DEPTH);
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_empty[p] <= 1'b1;
        end else begin
          rx_empty[p] <= cnt_nxt[Q] == '0;
        end
      end

      // fifo written by this port; the shared clock lets it stay one domain
      assign cnt_nxt[p] = cnt_r[p] + CW'(push[p]) - CW'(pop[p]);

      always_ff @(posedge pclk) begin
        if (push[p]) begin
          mem_r[p][wp_r[p]] <= apb_req[p].psel && MM ? apb_req[p].pwdata : s_strm[p].tdata;
        end
      end

      // pointers wrap naturally since depth is a power of two
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wp_r[p] <= '0;
        end else if (push[p]) begin
          wp_r[p] <= wp_r[p] + PW'(1);
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rp_r[p] <= '0;
        end else if (pop[p]) begin
          rp_r[p] <= rp_r[p] + PW'(1);
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r[p] <= '0;
        end else begin
          cnt_r[p] <= cnt_nxt[p];
        end
      end
    end
  endgenerate

endmodule // dpm_mailbox

//--- sim/dpm_checker.sv
// assertions on the mailbox ports
`timescale 1ns/1ps
module dpm_checker import dpm_pkg::*; (
  // clock and reset
  input wire logic            pclk,
  input wire logic            presetn,
  // buses and flags
  input wire dpm_apb_req_type apb_req [2],
  input wire dpm_apb_rsp_type apb_rsp [2],
  input wire logic            s_tready [2],
  input wire dpm_strm_type    m_strm [2],
  input wire logic            m_tready [2],
  input wire logic            rx_empty [2],
  input wire logic            tx_full [2],
  input wire logic            irq [2]
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_lite_ready: assert property ($rose(apb_req[0].penable) |=> apb_rsp[0].pready)
    else $error("lite answer late");
  chk_ready_pulse: assert property (apb_rsp[0].pready |=> !apb_rsp[0].pready)
    else $error("ready held");
  chk_strm_refuse: assert property (apb_rsp[1].pready |-> apb_rsp[1].pslverr)
    else $error("stream port took bus access");
  chk_err_ready: assert property (apb_rsp[0].pslverr |-> apb_rsp[0].pready)
    else $error("error without ready");
  chk_lite_nostrm: assert property (!s_tready[0])
    else $error("lite port takes stream");
  chk_full_block: assert property (tx_full[1] |-> !s_tready[1])
    else $error("ready while full");
  chk_out_hold: assert property (m_strm[1].tvalid && !m_tready[1] |=> m_strm[1].tvalid && $stable(m_strm[1].tdata))
    else $error("stream word dropped");
  chk_reset_state: assert property ($rose(presetn) |-> rx_empty[0] && !irq[0] && !irq[1])
    else $error("bad state after reset");
  cover property (apb_rsp[0].pready && apb_rsp[0].pslverr);
  cover property (m_strm[1].tvalid && m_tready[1]);
  cover property (irq[0]);
endmodule // dpm_checker

//--- sim/dpm_strm_peer.sv
// stream peer on port b: word source and stalling sink
`timescale 1ns/1ps
module dpm_strm_peer import dpm_pkg::*; (
  // clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // bench requests
  input wire logic          hold,
  input wire logic          snd_go,
  input wire logic [DW-1:0] snd_data,
  // mailbox side
  input wire logic          s_tready,
  output dpm_strm_type      s_strm,
  output logic              m_tready
);
  logic [DW-1:0] pend [$];
  int seed = 32'h9f2ebfee;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_strm <= '{tvalid: 1'b0, tdata: 32'h0};
      m_tready <= 1'b0;
    end else begin
      if (snd_go)
        pend.push_back(snd_data);
      // random stalls, hold forces the fifo to fill
      m_tready <= !hold && ($random(seed) % 3 != 0);
      if (!s_strm.tvalid || s_tready) begin
        if (pend.size() > 0)
          s_strm <= '{tvalid: 1'b1, tdata: pend.pop_front()};
        else
          s_strm <= '{tvalid: 1'b0, tdata: ~s_strm.tdata};
      end
    end
  end
endmodule // dpm_strm_peer

//--- sim/tb.sv
// bench for the mailbox: port a on apb, port b streaming
`timescale 1ns/1ps
module tb import dpm_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic hold = 1'b0;
  logic snd_go = 1'b0;
  logic [DW-1:0] snd_data = 32'h0;
  dpm_apb_req_type req [2] = '{default: '0};
  dpm_apb_rsp_type apb_rsp [2];
  wire dpm_strm_type s_strm [2];
  dpm_strm_type m_strm [2];
  logic s_tready [2], tx_full [2], rx_empty [2], irq [2];
  wire logic m_tready [2];
  logic [33:0] aq [$], e;
  logic [DW-1:0] sq [$], bq [$], w, w2;
  int seed = 32'h9f2ebfee;
  int err_total = 0, samples_checked = 0;
  always #2.5 pclk = ~pclk;
  assign s_strm[0] = '{tvalid: 1'b0, tdata: 32'h0};
  assign m_tready[0] = 1'b0;
  dpm_mailbox #(.port_b_interface_select(IF_STREAM)) uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(apb_rsp), .s_strm(s_strm), .s_tready(s_tready), .m_strm(m_strm), .m_tready(m_tready),
    .tx_full(tx_full), .rx_empty(rx_empty), .irq(irq));
  dpm_strm_peer peer (.pclk(pclk), .presetn(presetn), .hold(hold), .snd_go(snd_go), .snd_data(snd_data),
    .s_tready(s_tready[1]), .s_strm(s_strm[1]), .m_tready(m_tready[1]));
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic fail(input logic [DW-1:0] g, x);
    err_total++;
    $display("mismatch at %0t got %h exp %h", $time, g, x);
  endtask
  task automatic chk(input logic [DW-1:0] g, x);
    samples_checked++;
    if (g !== x)
      fail(g, x);
  endtask
  // e carries {data compared, pslverr, prdata}
  task automatic apb(input int p, input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d,
                     input logic [33:0] x);
    aq.push_back(x);
    req[p] <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: 4'($random(seed))};
    @(posedge pclk);
    req[p].penable <= 1'b1;
    // no wait-state count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (apb_rsp[p].pready !== 1'b1);
    req[p] <= '{default: '0};
    // idle edge so a back-to-back call never assigns req twice at once
    @(posedge pclk);
  endtask
  task automatic rd(input int p, input logic [AW-1:0] a, input logic [DW-1:0] x);
    apb(p, 1'b0, a, 32'h0, {2'b10, x});
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    apb(0, 1'b1, a, d, 34'h0);
  endtask
  always @(posedge pclk) begin
    for (int p = 0; p < 2; p++)
      if (apb_rsp[p].pready === 1'b1) begin
        e = aq.pop_front();
        samples_checked++;
        if (apb_rsp[p].pslverr !== e[32] || (e[33] && apb_rsp[p].prdata !== e[DW-1:0]))
          fail(apb_rsp[p].prdata, e[DW-1:0]);
      end
    if (m_strm[1].tvalid === 1'b1 && m_tready[1] === 1'b1) begin
      w2 = sq.pop_front();
      samples_checked++;
      if (m_strm[1].tdata !== w2)
        fail(m_strm[1].tdata, w2);
    end
  end
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(rx_empty[0], 32'h1);
    rd(0, OFF_INT_MSK, 32'h0);
    rd(0, OFF_STATUS, 32'h9);
    $display("test reset done");
    hold <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      w = $random(seed);
      // one word parks in port b's stalled output stage, so DEPTH + 1 are kept
      if (i <= DEPTH)
        sq.push_back(w);
      wr(OFF_WDATA, w);
    end
    chk(tx_full[0], 32'h1);
    chk(sq.size() >= DEPTH, 32'h1);
    // tx count fell back to its zero threshold when the first word moved out
    rd(0, OFF_INT_STS, 32'h6);
    hold <= 1'b0;
    for (int i = 0; i < 300 && sq.size() > 0; i++)
      @(posedge pclk);
    chk(sq.size(), 32'h0);
    $display("test fill and drain done");
    for (int i = 0; i < DEPTH; i++) begin
      snd_data <= $random(seed);
      snd_go <= 1'b1;
      @(posedge pclk);
      bq.push_back(snd_data);
    end
    snd_go <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(rx_empty[0], 32'h0);
    chk(tx_full[1], 32'h1);
    chk(s_tready[1], 32'h0);
    for (int i = 0; i < DEPTH; i++)
      rd(0, OFF_RDATA, bq.pop_front());
    rd(0, OFF_RDATA, 32'h0);
    rd(0, OFF_INT_STS, 32'h7);
    $display("test stream to bus done");
    chk(irq[0], 32'h0);
    wr(OFF_INT_MSK, 32'h2);
    @(posedge pclk);
    chk(irq[0], 32'h1);
    wr(OFF_INT_STS, 32'h7);
    @(posedge pclk);
    chk(irq[0], 32'h0);
    rd(0, OFF_INT_STS, 32'h0);
    apb(1, 1'b0, OFF_STATUS, 32'h0, {2'b01, 32'h0});
    apb(0, 1'b0, 8'h04, 32'h0, {2'b11, 32'h0});
    $display("test irq and refusal done");
    summarize();
  end
endmodule // tb
bind dpm_mailbox dpm_checker chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .s_tready(s_tready), .m_strm(m_strm), .m_tready(m_tready), .rx_empty(rx_empty), .tx_full(tx_full), .irq(irq));
